// [inc/acs_defs.svh]
// Functional notes
// - Set sequence-done flag at each sequence end
// - Clear done: write one, start, fast read
// - Edge mode: extra trigger while busy sets overrun
// - Overruns clear by write one or config write
// - Result write over set done flag flags overrun
// - Four-bit read-only counter names next result slot
// - Non-queue mode zeroes counter at sequence boundaries
// - Counter wraps to zero after its maximum
// - Abort or start clears counter always
// - Status always accessible; status writes never touch counter
// - Compare-enable at 0x8; writing it aborts sequence
// - Ten enable bits indexed by sequence position
// - Done flag reports compare success
// - Compared results are not stored
// - Operator one: greater; zero: lower or equal
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH
`define ACS_STATUS_OFFSET   12'h004
`define ACS_CMPE_OFFSET     12'h008
`define ACS_OPER_OFFSET     12'h00C
`define ACS_CCF_OFFSET      12'h010
`define ACS_RESULT_OFFSET   12'h040
`define ACS_SCF_BIT         7
`define ACS_TRIGGER_OVERRUN_FLAG_BIT       5
`define ACS_RESULT_OVERRUN_FLAG_BIT       4
`define ACS_CNT_MSB         3
`define ACS_NUM_SLOTS       10
`define ACS_CNT_MAX         4'h9
`define ACS_CMPE_RESET      10'h000
`define ACS_OPER_RESET      10'h000
`endif

// [inc/acs_pkg.sv]
package acs_pkg;
   // Events from the sequencer, one cycle each, with its busy level and result value.
   typedef struct packed {
      logic       seq_start;
      logic       seq_done;
      logic       conv_done;
      logic       abort;
      logic       trig_edge;
      logic       busy;
      logic [9:0] result;
   } acs_seq_t;
   // Static mode settings and the control-write strobe from the control registers.
   typedef struct packed {
      logic queue_mode;
      logic edge_mode;
      logic fast_clear;
      logic ctl_write;
   } acs_mode_t;
endpackage : acs_pkg

// [rtl/acs_slot.sv]
`timescale 1ns/1ps
// One conversion position: stores result or compare value and its done flag.
module acs_slot #(
   parameter int WIDTH = 10
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] conv_value,
   input  wire logic             cmp_en,
   input  wire logic             cmp_gt,
   input  wire logic             sw_write,
   input  wire logic [WIDTH-1:0] sw_value,
   input  wire logic             sw_clear,
   input  wire logic             start_clear,
   output logic [WIDTH-1:0]      value,
   output logic                  done,
   output logic                  overrun
);
   logic hit;

   // Compare sense chosen per position by the operator bit.
   always_comb
   begin
      hit = cmp_gt ? (conv_value > value) : (conv_value <= value);
   end

   // A compared result is thrown away so the reference value survives.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         value <= '0;
      else if (load && !cmp_en)
         value <= conv_value;
      else if (sw_write)
         value <= sw_value;
   end

   // Start wins over a set; other clears lose against a set.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         done <= 1'b0;
      else if (start_clear)
         done <= 1'b0;
      else if (load && (!cmp_en || hit))
         done <= 1'b1;
      else if (sw_clear)
         done <= 1'b0;
   end

   assign overrun = load && !cmp_en && done;
endmodule : acs_slot

// [rtl/acs_status.sv]
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "acs_defs.svh"
// Status and compare-enable logic of the converter sequencer, AHB-Lite slave.
module acs_status #(
   parameter int SLOTS = `ACS_NUM_SLOTS
) (
   input  wire logic                hclk,
   input  wire logic                hresetn,
   input  wire logic                hsel,
   input  wire logic [11:0]         haddr,
   input  wire logic [1:0]          htrans,
   input  wire logic                hwrite,
   input  wire logic [2:0]          hsize,
   input  wire logic [31:0]         hwdata,
   input  wire logic                hready,
   output logic [31:0]              hrdata,
   output logic                     hreadyout,
   output logic                     hresp,
   input  wire acs_pkg::acs_seq_t   seq,
   input  wire acs_pkg::acs_mode_t  mode,
   output logic                     abort_req
);
   logic [11:0]      a_addr;
   logic             a_wr;
   logic             a_rd;
   logic             wr;
   logic             rd;
   logic [11:0]      addr;
   logic             sequence_done_flag;
   logic             trigger_overrun_flag;
   logic             result_overrun_flag;
   logic [3:0]       conversion_counter;
   logic [SLOTS-1:0] compare_enable_bits;
   logic [SLOTS-1:0] compare_greater_select;
   logic [SLOTS-1:0] conversion_done_flag;
   logic [SLOTS-1:0] slot_ovr;
   logic [SLOTS-1:0] slot_load;
   logic [SLOTS-1:0] slot_wr;
   logic [SLOTS-1:0] slot_rd;
   logic [9:0]       slot_val [SLOTS];
   logic             w_status;
   logic             w_cmpe;
   logic             w_oper;
   logic             w_ccf;
   logic             res_read;
   logic             ovr_clear_all;
   logic [31:0]      next_hrdata;
   logic [SLOTS-1:0] slot_clear;
   logic [3:0]       next_conversion_counter;
   logic             scf_clear;
   logic             ovr_trig_clear;
   logic             ovr_result_clear;
   logic             trig_overrun_event;
   logic             result_overrun_event;
   logic             sel_status;
   logic             sel_cmpe;
   logic             sel_oper;
   logic             sel_ccf;

   // Address of the transfer in its data phase; writes decode against it because
   // the bus has already moved on to the next address by then.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         a_addr <= 12'h000;
      else if (hready)
         a_addr <= haddr;
   end

   // Transfer kind of the data phase; only NONSEQ or SEQ requests count.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         a_wr <= 1'b0;
         a_rd <= 1'b0;
      end
      else if (hready)
      begin
         a_wr <= hsel && htrans[1] && hwrite;
         a_rd <= hsel && htrans[1] && !hwrite;
      end
   end

   // Reads are served in the address phase so their data stands one edge later.
   assign wr   = a_wr;
   assign rd   = hsel && htrans[1] && !hwrite && hready;
   assign addr = haddr;

   // Writes act in the data phase, where hwdata is valid.
   assign w_status = wr && (a_addr == `ACS_STATUS_OFFSET);
   assign w_cmpe   = wr && (a_addr == `ACS_CMPE_OFFSET);
   assign w_oper   = wr && (a_addr == `ACS_OPER_OFFSET);
   assign w_ccf    = wr && (a_addr == `ACS_CCF_OFFSET);
   assign res_read = rd && (addr >= `ACS_RESULT_OFFSET)
                     && (addr < `ACS_RESULT_OFFSET + 12'(4 * SLOTS));
   // Any configuration write aborts and clears both overruns.
   assign ovr_clear_all = mode.ctl_write || w_cmpe || w_oper || seq.seq_start;

   // Clear terms gathered here; each flag's own process still lets its set win,
   // so an event in the cycle of a clear is never lost.
   assign scf_clear        = (w_status && hwdata[`ACS_SCF_BIT]) || seq.seq_start
                             || (mode.fast_clear && res_read);
   assign ovr_trig_clear   = (w_status && hwdata[`ACS_TRIGGER_OVERRUN_FLAG_BIT]) || ovr_clear_all;
   assign ovr_result_clear = (w_status && hwdata[`ACS_RESULT_OVERRUN_FLAG_BIT]) || ovr_clear_all;

   // A held level is not a new request, so level-trigger mode never flags an overrun.
   assign trig_overrun_event   = mode.edge_mode && seq.trig_edge && seq.busy;
   // Any slot overwritten while its done flag still stood has lost its data.
   assign result_overrun_event = |slot_ovr;

   // Per-slot strobes; the sequencer writes the slot the counter points at.
   always_comb
   begin
      for (int i = 0; i < SLOTS; i++)
      begin
         slot_load[i] = seq.conv_done && (conversion_counter == 4'(i));
         slot_wr[i]   = wr && (a_addr == `ACS_RESULT_OFFSET + 12'(4 * i));
         slot_rd[i]   = rd && (addr == `ACS_RESULT_OFFSET + 12'(4 * i));
      end
   end

   // Software clears of the done flags; the path depends on the fast-clear mode.
   // A compared slot holds a reference value, so in fast mode a write clears it.
   always_comb
   begin
      for (int i = 0; i < SLOTS; i++)
      begin
         if (!mode.fast_clear)
            slot_clear[i] = w_ccf && hwdata[i];
         else if (compare_enable_bits[i])
            slot_clear[i] = slot_wr[i];
         else
            slot_clear[i] = slot_rd[i];
      end
   end

   // One slot per conversion position, indexed by position and not by channel.
   genvar g;
   generate
      for (g = 0; g < SLOTS; g++)
      begin : g_slot
         acs_slot #(
            .WIDTH (10)
         ) u_slot (
            .hclk        (hclk),
            .hresetn     (hresetn),
            .load        (slot_load[g]),
            .conv_value  (seq.result),
            .cmp_en      (compare_enable_bits[g]),
            .cmp_gt      (compare_greater_select[g]),
            .sw_write    (slot_wr[g]),
            .sw_value    (hwdata[9:0]),
            .sw_clear    (slot_clear[g]),
            .start_clear (seq.seq_start),
            .value       (slot_val[g]),
            .done        (conversion_done_flag[g]),
            .overrun     (slot_ovr[g])
         );
      end
   endgenerate

   // Sequence-done: set wins over clears by write-one or fast read.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         sequence_done_flag <= 1'b0;
      else if (seq.seq_done)
         sequence_done_flag <= 1'b1;
      else if (scf_clear)
         sequence_done_flag <= 1'b0;
   end

   // Trigger overrun counts only edges in edge mode while a sequence runs.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         trigger_overrun_flag <= 1'b0;
      else if (trig_overrun_event)
         trigger_overrun_flag <= 1'b1;
      else if (ovr_trig_clear)
         trigger_overrun_flag <= 1'b0;
   end

   // Result overrun from any slot overwritten while its flag was set.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         result_overrun_flag <= 1'b0;
      else if (result_overrun_event)
         result_overrun_flag <= 1'b1;
      else if (ovr_result_clear)
         result_overrun_flag <= 1'b0;
   end

   // Next counter value; aborts and starts win, then the end of a sequence, then a
   // finished conversion, which steps on to the next slot.
   always_comb
   begin
      next_conversion_counter = conversion_counter;
      if (seq.abort || abort_req || seq.seq_start)
         next_conversion_counter = 4'h0;
      else if (seq.seq_done && !mode.queue_mode)
         next_conversion_counter = 4'h0;
      else if (seq.conv_done && (conversion_counter == `ACS_CNT_MAX))
         next_conversion_counter = 4'h0;
      else if (seq.conv_done)
         next_conversion_counter = conversion_counter + 4'h1;
   end

   // Counter is hardware-only; status writes never reach it.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         conversion_counter <= 4'h0;
      else
         conversion_counter <= next_conversion_counter;
   end

   // Compare enable mask; a write to it also aborts the sequence below.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         compare_enable_bits <= `ACS_CMPE_RESET;
      else if (w_cmpe)
         compare_enable_bits <= hwdata[SLOTS-1:0];
   end

   // Compare operator bits, one per position.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         compare_greater_select <= `ACS_OPER_RESET;
      else if (w_oper)
         compare_greater_select <= hwdata[SLOTS-1:0];
   end

   // Abort pulse one cycle after a compare, operator or control write; registering
   // it keeps the sequencer's abort off the bus decode path.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         abort_req <= 1'b0;
      else
         abort_req <= w_cmpe || w_oper || mode.ctl_write;
   end

   // Register selects for the read mux, decoded from the address-phase address.
   assign sel_status = (addr == `ACS_STATUS_OFFSET);
   assign sel_cmpe   = (addr == `ACS_CMPE_OFFSET);
   assign sel_oper   = (addr == `ACS_OPER_OFFSET);
   assign sel_ccf    = (addr == `ACS_CCF_OFFSET);

   // Read mux; unmapped addresses read as zero.
   always_comb
   begin
      next_hrdata = 32'h0000_0000;
      if (sel_status)
         next_hrdata = {24'h000000, sequence_done_flag, 1'b0, trigger_overrun_flag,
                        result_overrun_flag, conversion_counter};
      else if (sel_cmpe)
         next_hrdata = {22'h000000, compare_enable_bits};
      else if (sel_oper)
         next_hrdata = {22'h000000, compare_greater_select};
      else if (sel_ccf)
         next_hrdata = {22'h000000, conversion_done_flag};
      for (int i = 0; i < SLOTS; i++)
         if (addr == `ACS_RESULT_OFFSET + 12'(4 * i))
            next_hrdata = {22'h000000, slot_val[i]};
   end

   // Zero-wait slave: read data registered at the address-phase edge.
   // It then stands through the data phase and until the next read.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata <= 32'h0000_0000;
      else if (rd)
         hrdata <= next_hrdata;
   end

   // Always ready once out of reset, so the bus never waits on this slave.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hreadyout <= 1'b0;
      else
         hreadyout <= 1'b1;
   end

   // Every transfer is answered OKAY; no access is refused.
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hresp <= 1'b0;
      else
         hresp <= 1'b0;
   end

   // Transfer size is ignored, as every register is one whole word.
   // The read kind of the data phase is kept for symmetry but not needed.
   logic unused_ok;
   assign unused_ok = ^{hsize, a_rd};
endmodule : acs_status

// [verification/acs_status_checker.sv]
`timescale 1ns/1ps
// Watches the status block only at its own ports.
module acs_status_checker #(
   parameter int SLOTS = 10
) (
   input wire logic               hclk,
   input wire logic               hresetn,
   input wire logic               hsel,
   input wire logic [11:0]        haddr,
   input wire logic [1:0]         htrans,
   input wire logic               hwrite,
   input wire logic               hready,
   input wire logic [31:0]        hrdata,
   input wire logic               hreadyout,
   input wire logic               hresp,
   input wire acs_pkg::acs_seq_t  seq,
   input wire acs_pkg::acs_mode_t mode,
   input wire logic               abort_req
);
   // Address phases decoded once, so each property stays short.
   wire logic ap    = hsel && htrans[1] && hready;
   wire logic rd_st = ap && !hwrite && haddr == 12'h004;
   wire logic rd_cm = ap && !hwrite && haddr == 12'h008;
   wire logic wr_cm = ap && hwrite && haddr == 12'h008;
   wire logic rd_un = ap && !hwrite && haddr == 12'h020;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_resp_okay: assert property (hresp == 1'h0)
      else $error("error response seen");
   chk_ready_zero_wait: assert property ($past(hresetn) |-> hreadyout)
      else $error("wait state inserted");
   chk_abort_ctl: assert property (mode.ctl_write |=> abort_req)
      else $error("control write did not abort");
   chk_abort_cmpe: assert property (wr_cm |-> ##[1:2] abort_req)
      else $error("compare enable write did not abort");
   chk_unmapped_zero: assert property (rd_un |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   chk_status_shape: assert property (rd_st |=> hrdata[31:8] == 24'h0 && !hrdata[6]
      && hrdata[3:0] < SLOTS) else $error("status field out of range");
   chk_cmpe_width: assert property (rd_cm |=> hrdata[31:SLOTS] == '0)
      else $error("compare enable too wide");
   chk_done_sets: assert property (seq.seq_done ##1 rd_st |=> hrdata[7])
      else $error("sequence done flag not set");
   chk_trig_over: assert property ((mode.edge_mode && seq.busy && seq.trig_edge)
      ##1 rd_st |=> hrdata[5]) else $error("trigger overrun not set");
   // The main scenarios reach these points.
   cover property (seq.seq_done ##1 rd_st);
   cover property (abort_req);
   cover property (mode.edge_mode && seq.trig_edge && seq.busy);
endmodule : acs_status_checker

bind acs_status acs_status_checker #(.SLOTS(SLOTS)) chk_i (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .seq(seq), .mode(mode),
   .abort_req(abort_req));

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
   logic                hclk      = 1'h0;
   logic                hresetn   = 1'h0;
   logic                hsel      = 1'h0;
   logic                hwrite    = 1'h0;
   logic [11:0]         haddr     = 12'h0;
   logic [1:0]          htrans    = 2'h0;
   logic [2:0]          hsize     = 3'h2;
   logic [31:0]         hwdata    = 32'h0;
   logic [31:0]         hrdata;
   logic [31:0]         q;
   logic                hreadyout;
   logic                hresp;
   logic                abort_req;
   acs_pkg::acs_seq_t   seq       = '0;
   acs_pkg::acs_mode_t  mode      = '0;
   int                  errors    = 0;
   int                  check_count = 0;
   int                  cyc       = 0;

   always #5 hclk = ~hclk;

   // The single slave's ready closes the loop back to its own input.
   acs_status acs_status_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .seq(seq), .mode(mode), .abort_req(abort_req));

   task wrap_up;
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up

   // A hang would otherwise never reach the verdict.
   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 2000)
      begin
         errors++;
         wrap_up();
      end
   end

   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // One single transfer; the master never assumes a latency.
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'h1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'h1);
      q = hrdata;
   endtask : xfer

   task rd(input logic [11:0] a, input logic [31:0] e, input string nm);
      xfer(1'h0, a, 32'h0);
      chk(nm, e, q);
   endtask : rd

   // Holds a sequencer event for n cycles, then drops it.
   task pulse(input logic [15:0] v, input int n);
      seq <= acs_pkg::acs_seq_t'(v);
      repeat (n) @(posedge hclk);
      seq <= '0;
   endtask : pulse

   task t_cmpe;
      xfer(1'h1, 12'h008, 32'hFFFFFFFF);
      rd(12'h008, 32'h3FF, "cmpe");
      xfer(1'h1, 12'h008, 32'h0);
   endtask : t_cmpe

   // Eleven back-to-back results wrap the counter and overwrite slot zero.
   task t_queue;
      mode.queue_mode <= 1'h1;
      // The abort from the mask write clears the counter at the next edge; let it pass.
      @(posedge hclk);
      pulse(16'h2055, 11);
      rd(12'h004, 32'h11, "wrap");
      xfer(1'h1, 12'h004, 32'h1F);
      rd(12'h004, 32'h01, "w1c");
      pulse(16'h1000, 1);
      rd(12'h004, 32'h0, "abort");
   endtask : t_queue

   task t_trig;
      mode.edge_mode <= 1'h1;
      pulse(16'h0C00, 1);
      rd(12'h004, 32'h20, "trig");
      mode.ctl_write <= 1'h1;
      @(posedge hclk);
      mode.ctl_write <= 1'h0;
      rd(12'h004, 32'h0, "ctl");
   endtask : t_trig

   task t_seq;
      mode.queue_mode <= 1'h0;
      pulse(16'h8000, 1);
      @(posedge hclk);
      pulse(16'h2001, 3);
      @(posedge hclk);
      pulse(16'h4000, 1);
      rd(12'h004, 32'h80, "seqend");
      xfer(1'h1, 12'h004, 32'h80);
      rd(12'h004, 32'h0, "scf");
   endtask : t_seq

   // Slot 0 wants greater, slot 1 lower-or-equal; a result of 0x200 hits only slot 0.
   task t_cmp;
      xfer(1'h1, 12'h008, 32'h3);
      xfer(1'h1, 12'h00C, 32'h1);
      xfer(1'h1, 12'h040, 32'h100);
      xfer(1'h1, 12'h044, 32'h100);
      pulse(16'h8000, 1);
      @(posedge hclk);
      pulse(16'h2200, 2);
      rd(12'h010, 32'h1, "cmpok");
      rd(12'h040, 32'h100, "keep");
   endtask : t_cmp

   // With fast clear on, reading a result register clears the sequence-done flag.
   task t_fast;
      xfer(1'h1, 12'h008, 32'h0);
      pulse(16'h8000, 1);
      @(posedge hclk);
      pulse(16'h6003, 1);
      rd(12'h004, 32'h80, "scfset");
      mode.fast_clear <= 1'h1;
      rd(12'h040, 32'h3, "res0");
      rd(12'h004, 32'h0, "fastclr");
      mode.fast_clear <= 1'h0;
   endtask : t_fast

   initial
   begin
      repeat (12) @(posedge hclk);
      hresetn <= 1'h1;
      repeat (2) @(posedge hclk);
      rd(12'h004, 32'h0, "st0");
      rd(12'h020, 32'h0, "unmap");
      t_cmpe();
      t_queue();
      t_trig();
      t_seq();
      t_cmp();
      t_fast();
      wrap_up();
   end
endmodule : testbench
